/* File: rtl/ldr_pkg.sv */
package ldr_pkg;

  localparam int          CH_N       = 28;
  localparam logic [4:0]  ADDR_HI    = 5'h0f;
  localparam logic [7:0]  REG_SHDN   = 8'h00;
  localparam logic [7:0]  DUTY_BASE  = 8'h05;
  localparam logic [7:0]  DUTY_LAST  = 8'h20;
  localparam logic [7:0]  REG_APPLY  = 8'h25;
  localparam logic [7:0]  CTL_BASE   = 8'h2a;
  localparam logic [7:0]  CTL_LAST   = 8'h45;
  localparam logic [7:0]  REG_GLOBAL = 8'h4a;
  localparam logic [7:0]  REG_SRST   = 8'h4f;
  localparam logic [7:0]  CMD_KEY    = 8'h00;
  localparam logic [7:0]  DUTY_RST   = 8'h00;
  localparam logic [2:0]  CTL_RST    = 3'h0;
  localparam logic        SHDN_RST   = 1'b0;
  localparam logic        GEN_RST    = 1'b0;
  localparam int          CTL_ON_BIT = 0;

  // controller timing and its own register map
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SCL_PERIOD_NS = 48;
  localparam int          QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0]  CSR_CMD       = 4'h0;
  localparam logic [3:0]  CSR_STATUS    = 4'h4;
  localparam int          CMD_START_BIT = 8;
  localparam int          CMD_STOP_BIT  = 9;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_NACK_BIT   = 1;

  typedef enum logic [1:0] {STRAP_GND, STRAP_VCC, STRAP_SCL, STRAP_SDA}
    ldr_strap_t;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_DATA, D_ACK, D_SKIP}
    ldr_dev_st_t;

  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_PARK, M_STOP}
    ldr_mst_st_t;

  function automatic logic [1:0] strap_bits(input ldr_strap_t s);
    unique case (s)
      STRAP_GND: strap_bits = 2'h0;
      STRAP_VCC: strap_bits = 2'h3;
      STRAP_SCL: strap_bits = 2'h1;
      STRAP_SDA: strap_bits = 2'h2;
    endcase
  endfunction : strap_bits

  function automatic logic in_win(input logic [7:0] p,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_win = (p >= lo) && (p <= hi);
  endfunction : in_win

  function automatic logic [4:0] ch_idx(input logic [7:0] p,
                                        input logic [7:0] base);
    logic [7:0] d;
    d = p - base;
    ch_idx = d[4:0];
  endfunction : ch_idx

endpackage : ldr_pkg

/* File: rtl/ldr_i2c_if.sv */
`timescale 1ns/1ps
interface ldr_i2c_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire  sda;

  // open drain with pull-up: any enabled low driver wins
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface : ldr_i2c_if

/* File: rtl/ldr_dev.sv */
`timescale 1ns/1ps
// Overview of operation
// [RULE1] answer only address 01111 plus strap bits
// [RULE2] strap gnd/vcc/scl/sda gives 00/11/01/10
// [RULE3] master always sends write bit zero
// [RULE4] sample data while clock high; idle high
// [RULE5] data fall with clock high is start
// [RULE6] address byte sent msb first, stable high
// [RULE7] matching address gets ack low pulse
// [RULE8] master stops and abandons on no ack
// [RULE9] pointer byte acked and loaded
// [RULE10] each data byte msb first and acked
// [RULE11] data rise with clock high stops
// [RULE12] pointer increments on each data ack
// [RULE13] 28 duty registers at 05h..20h, zero
// [RULE14] 00h bit0: 0 shutdown, 1 normal
// [RULE15] average current is scale times duty/256
// [RULE16] duty and control staged until 25h zero
// [RULE17] control bit0 turns channel on, default off
// [RULE18] control bits 2:1 choose current scale
// [RULE19] 4Ah bit0 global enable, resets zero
// [RULE20] zero to 4Fh restores all defaults
// [RULE21] power-up gives defaults, outputs dark
// [RULE22] global bit 1 forces all outputs off
// [RULE23] nonzero commands, unmapped writes ignored
// [RULE24] no ack for read bit, no readback
module ldr_dev
  import ldr_pkg::*;
(
  input  wire logic         CLK_I,
  input  wire logic         RST_N_I,
  input  wire ldr_strap_t   STRAP_I,
  ldr_i2c_if.slave          BUS,
  output logic [CH_N-1:0]   LED_O,
  output logic              SW_POWER_DOWN_O,
  output logic              GLOBAL_OFF_O,
  output logic [CH_N-1:0]   CH_ON_O,
  output logic [2*CH_N-1:0] CURRENT_SCALE_SEL_O,
  output logic [8*CH_N-1:0] DUTY_O
);

  logic [2:0]   scl_s_q;
  logic [2:0]   sda_s_q;
  ldr_strap_t   strap_m_q;
  ldr_strap_t   strap_q;
  logic         strap_ok_q;
  ldr_dev_st_t  state_q;
  ldr_dev_st_t  nxt_q;
  logic [3:0]   cnt_q;
  logic [7:0]   shreg_q;
  logic [7:0]   ptr_q;
  logic         ack_q;
  logic [7:0]   duty_sh_q  [CH_N];
  logic [2:0]   ctl_sh_q   [CH_N];
  logic [7:0]   duty_act_q [CH_N];
  logic [2:0]   ctl_act_q  [CH_N];
  logic         shdn_q;
  logic         gen_q;
  logic [7:0]   pwm_q;
  logic [CH_N-1:0] led_q;

  wire scl_h = scl_s_q[1];
  wire scl_p = scl_s_q[2];
  wire sda_h = sda_s_q[1];
  wire sda_p = sda_s_q[2];

  // [RULE5] start detect
  wire start_w = scl_h & scl_p & sda_p & ~sda_h;
  // [RULE11] stop detect
  wire stop_w  = scl_h & scl_p & ~sda_p & sda_h;
  // [RULE4] sample on clock rise
  wire rise_w  = scl_h & ~scl_p;
  wire fall_w  = ~scl_h & scl_p;
  wire byte_w  = fall_w & (cnt_q == 4'h8);

  // [RULE1] own address, write bit zero
  wire [7:0] own_w   = {ADDR_HI, strap_bits(strap_q), 1'b0};
  // [RULE24] read bit never matches
  wire       match_w = (shreg_q == own_w);

  wire       wr_w    = byte_w & (state_q == D_DATA);
  wire       duty_w  = wr_w & in_win(ptr_q, DUTY_BASE, DUTY_LAST);
  wire       ctl_w   = wr_w & in_win(ptr_q, CTL_BASE, CTL_LAST);
  wire [4:0] duty_ix = ch_idx(ptr_q, DUTY_BASE);
  wire [4:0] ctl_ix  = ch_idx(ptr_q, CTL_BASE);
  // [RULE23] commands need the zero key
  wire       key_w   = (shreg_q == CMD_KEY);
  wire       apply_w = wr_w & (ptr_q == REG_APPLY) & key_w;
  wire       srst_w  = wr_w & (ptr_q == REG_SRST) & key_w;
  wire       clr_w   = ~RST_N_I | srst_w;

  // first stage only feeds the second; third keeps the previous value
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], BUS.scl};
      sda_s_q <= {sda_s_q[1:0], BUS.sda};
    end
  end

  always_ff @(posedge CLK_I)
  begin
    strap_m_q <= STRAP_I;
  end

  // [RULE2] strap caught once after reset release
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      strap_q    <= STRAP_GND;
      strap_ok_q <= 1'b0;
    end
    else if (!strap_ok_q)
    begin
      strap_q    <= strap_m_q;
      strap_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_q <= D_IDLE;
      nxt_q   <= D_IDLE;
      cnt_q   <= 4'h0;
      shreg_q <= 8'h00;
      ptr_q   <= 8'h00;
      ack_q   <= 1'b0;
    end
    else if (start_w)
    begin
      // a repeated start also lands here
      state_q <= D_ADDR;
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
    end
    else if (stop_w)
    begin
      state_q <= D_IDLE;
      ack_q   <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        D_ADDR, D_PTR, D_DATA:
        begin
          if (rise_w)
          begin
            shreg_q <= {shreg_q[6:0], sda_h};
            cnt_q   <= cnt_q + 4'h1;
          end
          else if (byte_w)
          begin
            cnt_q <= 4'h0;
            // [RULE7] ack only a matching address
            ack_q <= (state_q != D_ADDR) | match_w;
            state_q <= (state_q == D_ADDR && !match_w) ? D_SKIP : D_ACK;
            nxt_q <= (state_q == D_ADDR) ? D_PTR : D_DATA;
            // [RULE9] pointer load
            if (state_q == D_PTR)
            begin
              ptr_q <= shreg_q;
            end
            // [RULE12] pointer increment
            if (state_q == D_DATA)
            begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        D_ACK:
        begin
          // [RULE10] ack held until next clock fall
          if (fall_w)
          begin
            ack_q   <= 1'b0;
            state_q <= nxt_q;
          end
        end
        D_IDLE, D_SKIP:
        begin
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // [RULE20] soft reset shares the power-up path
  // [RULE21] power-up defaults
  always_ff @(posedge CLK_I)
  begin
    if (clr_w)
    begin
      for (int i = 0; i < CH_N; i++)
      begin
        duty_sh_q[i]  <= DUTY_RST;
        ctl_sh_q[i]   <= CTL_RST;
        duty_act_q[i] <= DUTY_RST;
        ctl_act_q[i]  <= CTL_RST;
      end
      shdn_q <= SHDN_RST;
      gen_q  <= GEN_RST;
    end
    else
    begin
      // [RULE13] duty shadow write
      if (duty_w)
      begin
        duty_sh_q[duty_ix] <= shreg_q;
      end
      // [RULE17] control shadow write
      if (ctl_w)
      begin
        ctl_sh_q[ctl_ix] <= shreg_q[2:0];
      end
      // [RULE14] shutdown bit
      if (wr_w && ptr_q == REG_SHDN)
      begin
        shdn_q <= shreg_q[0];
      end
      // [RULE19] global enable bit
      if (wr_w && ptr_q == REG_GLOBAL)
      begin
        gen_q <= shreg_q[0];
      end
      // [RULE16] apply shadow to active
      if (apply_w)
      begin
        for (int i = 0; i < CH_N; i++)
        begin
          duty_act_q[i] <= duty_sh_q[i];
          ctl_act_q[i]  <= ctl_sh_q[i];
        end
      end
    end
  end

  // [RULE15] 256-step duty against a free counter
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      pwm_q <= 8'h00;
      led_q <= '0;
    end
    else
    begin
      pwm_q <= pwm_q + 8'h01;
      for (int i = 0; i < CH_N; i++)
      begin
        // [RULE22] global bit high forces dark
        led_q[i] <= ctl_act_q[i][CTL_ON_BIT] & shdn_q & ~gen_q &
                    (pwm_q < duty_act_q[i]);
      end
    end
  end

  for (genvar g = 0; g < CH_N; g++)
  begin : g_out
    assign DUTY_O[g*8 +: 8]              = duty_act_q[g];
    assign CH_ON_O[g]                    = ctl_act_q[g][CTL_ON_BIT];
    // [RULE18] scale code passed out
    assign CURRENT_SCALE_SEL_O[g*2 +: 2] = ctl_act_q[g][2:1];
  end

  assign LED_O           = led_q;
  assign SW_POWER_DOWN_O = ~shdn_q;
  assign GLOBAL_OFF_O    = gen_q;
  // only ever pulls low; no read data path exists
  assign BUS.sda_s_o     = 1'b0;
  assign BUS.sda_s_oe    = ack_q;

endmodule : ldr_dev

/* File: rtl/ldr_mst.sv */
`timescale 1ns/1ps
module ldr_mst
  import ldr_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  ldr_i2c_if.master        BUS
);

  localparam logic [3:0] DIV_LAST = 4'(QUARTER_CYC - 1);

  logic [1:0]  sda_s_q;
  ldr_mst_st_t state_q;
  logic [3:0]  div_q;
  logic [1:0]  qc_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic        stop_q;
  logic        scl_q;
  logic        low_q;
  logic        nack_q;
  logic        rd_done_q;
  logic [31:0] rdata_q;

  wire sda_h  = sda_s_q[1];
  wire busy_w = (state_q != M_IDLE);
  wire cmd_w  = AVS_WRITE_I & (AVS_ADDRESS_I == CSR_CMD);
  wire acc_w  = cmd_w & ~busy_w;
  wire rd_w   = AVS_READ_I & ~rd_done_q;
  wire tick_w = busy_w & (div_q == DIV_LAST);
  wire [31:0] stat_w = {30'h0000_0000, nack_q, busy_w};

  // a command write stalls while a byte is still on the wire
  assign AVS_WAITREQUEST_O = (cmd_w & busy_w) | rd_w;
  assign AVS_READDATA_O    = rdata_q;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      sda_s_q   <= 2'h3;
      rd_done_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      sda_s_q   <= {sda_s_q[0], BUS.sda};
      rd_done_q <= rd_w;
      if (rd_w)
      begin
        rdata_q <= (AVS_ADDRESS_I == CSR_STATUS) ? stat_w : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_q <= M_IDLE;
      div_q   <= 4'h0;
      qc_q    <= 2'h0;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      stop_q  <= 1'b0;
      // [RULE4] bus idles high
      scl_q   <= 1'b1;
      low_q   <= 1'b0;
      nack_q  <= 1'b0;
    end
    else if (acc_w)
    begin
      // [RULE3] write bit forced to zero after a start
      sh_q    <= AVS_WRITEDATA_I[CMD_START_BIT] ?
                 {AVS_WRITEDATA_I[7:1], 1'b0} : AVS_WRITEDATA_I[7:0];
      stop_q  <= AVS_WRITEDATA_I[CMD_STOP_BIT];
      state_q <= AVS_WRITEDATA_I[CMD_START_BIT] ? M_START : M_BIT;
      div_q   <= 4'h0;
      qc_q    <= 2'h0;
      bit_q   <= 4'h0;
      nack_q  <= 1'b0;
    end
    else if (busy_w)
    begin
      div_q <= tick_w ? 4'h0 : div_q + 4'h1;
      if (tick_w)
      begin
        qc_q <= qc_q + 2'h1;
        unique case (state_q)
          M_START:
          begin
            // [RULE5] data falls while clock high
            if (qc_q == 2'h0) low_q <= 1'b0;
            if (qc_q == 2'h1) scl_q <= 1'b1;
            if (qc_q == 2'h2) low_q <= 1'b1;
            if (qc_q == 2'h3) state_q <= M_BIT;
          end
          M_BIT:
          begin
            if (qc_q == 2'h0) scl_q <= 1'b0;
            // [RULE6] msb first, changed only while clock low
            // [RULE10] ack slot releases the line
            if (qc_q == 2'h1) low_q <= (bit_q < 4'h8) & ~sh_q[7];
            if (qc_q == 2'h2) scl_q <= 1'b1;
            if (qc_q == 2'h3)
            begin
              if (bit_q == 4'h8)
              begin
                // [RULE8] no ack forces stop
                nack_q  <= sda_h;
                state_q <= (sda_h | stop_q) ? M_STOP : M_PARK;
              end
              else
              begin
                sh_q  <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          M_PARK:
          begin
            // clock parked low between bytes
            scl_q   <= 1'b0;
            qc_q    <= 2'h0;
            state_q <= M_IDLE;
          end
          M_STOP:
          begin
            // [RULE11] data rises while clock high
            if (qc_q == 2'h0) scl_q <= 1'b0;
            if (qc_q == 2'h1) low_q <= 1'b1;
            if (qc_q == 2'h2) scl_q <= 1'b1;
            if (qc_q == 2'h3)
            begin
              low_q   <= 1'b0;
              state_q <= M_IDLE;
            end
          end
          M_IDLE:
          begin
            qc_q <= 2'h0;
          end
        endcase
      end
    end
  end

  assign BUS.scl      = scl_q;
  assign BUS.sda_m_o  = 1'b0;
  assign BUS.sda_m_oe = low_q;

endmodule : ldr_mst

/* File: dv/ldr_link_properties.sv */
`timescale 1ns/1ps
module ldr_link_properties (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  wire        hi    = scl & scl_q;
  wire        start = hi & sda_q & ~sda;
  wire        stop  = hi & ~sda_q & sda;
  wire        rise  = scl & ~scl_q;
  wire [3:0]  bit_n = (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;

  // count restarts at every start so a repeated start stays aligned
  assign bit_d = start ? 4'h0 : (rise ? bit_n : bit_q);

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      bit_q <= bit_d;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_idle_after_reset: assert property (
    $rose(RST_N_I) |-> scl && sda)
    else $error("bus not idle after reset");
  a_start_then_low: assert property (
    start |-> ##[1:16] !scl)
    else $error("clock not low after start");
  a_ack_rise_low: assert property (
    $rose(sda_s_oe) |-> !scl)
    else $error("ack raised with clock high");
  a_ack_fall_low: assert property (
    $fell(sda_s_oe) |-> !scl)
    else $error("ack dropped with clock high");
  a_ack_holds_high: assert property (
    $rose(scl) && sda_s_oe |=> sda_s_oe[*5])
    else $error("ack not held over high phase");
  a_master_released: assert property (
    sda_s_oe && scl |-> !sda_m_oe)
    else $error("master drives data during ack");
  a_ack_on_ninth: assert property (
    sda_s_oe && hi |-> bit_q == 4'h9)
    else $error("ack outside ninth clock");
  a_ack_drops_soon: assert property (
    $fell(scl) && bit_q == 4'h9 |-> ##[1:5] !sda_s_oe)
    else $error("ack held too long");
  a_stop_idle_high: assert property (
    stop |=> (scl && sda)[*3])
    else $error("bus not idle after stop");
endmodule : ldr_link_properties

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb
  import ldr_pkg::*;
;
  localparam logic [1:0] AD_TBL [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic              clk;
  logic              rst_n;
  logic [3:0]        adr;
  logic              rd;
  logic              wr;
  logic [31:0]       wd;
  logic [31:0]       rdata;
  logic              wreq;
  ldr_strap_t        strap;
  logic [CH_N-1:0]   led;
  logic              spd;
  logic              goff;
  logic [CH_N-1:0]   chon;
  logic [2*CH_N-1:0] scale;
  logic [8*CH_N-1:0] duty;
  logic [31:0]       rsp;
  logic [7:0]        dev;
  logic              nack;
  int                n_mismatch;
  int                n_tests;

  ldr_i2c_if bus ();
  ldr_mst u_ldr_mst (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .BUS(bus.master));
  ldr_dev u_ldr_dev (.CLK_I(clk), .RST_N_I(rst_n), .STRAP_I(strap),
    .BUS(bus.slave), .LED_O(led), .SW_POWER_DOWN_O(spd),
    .GLOBAL_OFF_O(goff), .CH_ON_O(chon), .CURRENT_SCALE_SEL_O(scale),
    .DUTY_O(duty));
  ldr_link_properties u_ldr_link_properties (.CLK_I(clk), .RST_N_I(rst_n),
    .scl(bus.scl), .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe),
    .sda(bus.sda));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // request held until the edge that samples waitrequest low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    rsp = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : av

  task automatic cmd(input logic [9:0] c);
    av(1'b1, CSR_CMD, {22'h0, c});
    do
      av(1'b0, CSR_STATUS, 32'h0);
    while (rsp[ST_BUSY_BIT] !== 1'b0);
    nack = rsp[ST_NACK_BIT];
  endtask : cmd

  // the controller itself sends stop after a refused address
  task automatic xfer(input logic [7:0] ad, input logic [7:0] p,
                      input logic [15:0] d, input int n);
    cmd({2'b01, ad});
    if (nack !== 1'b0)
      return;
    cmd({n == 0, 1'b0, p});
    for (int i = 0; i < n; i++)
      cmd({i == n - 1, 1'b0, d[15-8*i -: 8]});
  endtask : xfer

  task automatic do_reset(input ldr_strap_t s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    dev = {ADDR_HI, AD_TBL[s], 1'b0};
  endtask : do_reset

  task automatic chk_dflt;
    chk(duty, '0);
    chk(chon, '0);
    chk(scale, '0);
    chk(goff, 1'b0);
    chk(spd, 1'b1);
    chk(led, '0);
  endtask : chk_dflt

  // lit cycles of channel 0 over one whole duty period
  task automatic led_cnt(output int c);
    c = 0;
    repeat (256)
    begin
      @(posedge clk);
      if (led[0] === 1'b1)
        c++;
    end
  endtask : led_cnt

  task automatic t_strap(input ldr_strap_t s);
    do_reset(s);
    chk_dflt();
    xfer(dev, REG_SHDN, 16'h0000, 0);
    chk(nack, 1'b0);
    xfer(dev ^ 8'h06, REG_SHDN, 16'h0000, 0);
    chk(nack, 1'b1);
    xfer(dev ^ 8'h08, REG_SHDN, 16'h0000, 0);
    chk(nack, 1'b1);
  endtask : t_strap

  task automatic t_stage;
    xfer(dev, DUTY_LAST - 8'h01, 16'h1122, 2);
    xfer(dev, CTL_BASE, 16'h0703, 2);
    chk(duty, '0);
    chk(chon, '0);
    xfer(dev, REG_APPLY, 16'h5a00, 1);
    chk(duty, '0);
    xfer(dev, 8'h21, 16'h5500, 1);
    chk(nack, 1'b0);
    xfer(dev, REG_APPLY, 16'h0000, 1);
    chk(duty[8*CH_N-1 -: 16], 16'h2211);
    chk(chon[1:0], 2'h3);
    chk(scale[3:0], 4'h7);
  endtask : t_stage

  // channel 0 is on from t_stage; give it a quarter duty
  task automatic t_direct;
    int c;
    xfer(dev, DUTY_BASE, 16'h4000, 1);
    xfer(dev, REG_APPLY, 16'h0000, 1);
    chk(duty[7:0], 8'h40);
    led_cnt(c);
    chk(c, 0);
    xfer(dev, REG_SHDN, 16'h0100, 1);
    chk(spd, 1'b0);
    led_cnt(c);
    chk(c, 32'h0000_0040);
    xfer(dev, REG_GLOBAL, 16'h0100, 1);
    chk(goff, 1'b1);
    led_cnt(c);
    chk(c, 0);
    chk(led, '0);
  endtask : t_direct

  task automatic t_soft;
    xfer(dev, REG_SRST, 16'h0100, 1);
    chk(goff, 1'b1);
    xfer(dev, REG_SRST, 16'h0000, 1);
    chk_dflt();
    xfer(dev, REG_APPLY, 16'h0000, 1);
    chk(duty, '0);
  endtask : t_soft

  initial
  begin
    rst_n = 1'b0;
    adr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    strap = STRAP_GND;
    n_mismatch = 0;
    n_tests = 0;
    for (int s = 0; s < 4; s++)
      t_strap(ldr_strap_t'(s));
    t_stage();
    t_direct();
    t_soft();
    report_and_stop();
  end

  // about six times the expected run length
  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb
